// [hdl/uvrb_map.vh]
// uvrb_map.vh: addresses, field positions and reset values of the vendor
// register bank. assumes 8-bit ulpi register data and 6-bit addresses.
`ifndef UVRB_MAP_VH
`define UVRB_MAP_VH

// ****************************************
// address window and register addresses
// ****************************************
`define UVRB_WIN_LO 6'h30
`define UVRB_WIN_HI 6'h3F
`define UVRB_A_BOOST 6'h31
`define UVRB_A_HSET 6'h33
`define UVRB_A_IDC 6'h36
`define UVRB_A_IDC_SET 6'h37
`define UVRB_A_IDC_CLR 6'h38
`define UVRB_A_PWR 6'h39
`define UVRB_A_PWR_SET 6'h3A
`define UVRB_A_PWR_CLR 6'h3B

// ****************************************
// field layouts
// ****************************************
`define UVRB_BOOST_MASK 8'h60
`define UVRB_BOOST_LSB 5
`define UVRB_HSET_MASK 8'h0F
`define UVRB_HSET_KEY 4'hA
`define UVRB_IDC_CODE_MASK 8'h07
`define UVRB_IDC_DONE 3
`define UVRB_IDC_START 4
`define UVRB_IDC_RSVD5 5
`define UVRB_IDC_IRQEN 6
`define UVRB_IDC_WMASK 8'h70
`define UVRB_PWR_WMASK 8'hFE
`define UVRB_PWR_SWAP 1
`define UVRB_PWR_ULVL_LSB 2
`define UVRB_PWR_PUP 4
`define UVRB_PWR_PUM 5
`define UVRB_PWR_USBLVL_LSB 6
`define UVRB_LATCH_BIT 3

// ****************************************
// reset values and encodings
// ****************************************
`define UVRB_BOOST_RST 8'h00
`define UVRB_HSET_RST 8'h00
`define UVRB_IDC_RST 8'h00
`define UVRB_PWR_RST 8'h04
`define UVRB_LVL_3V3 2'h0

// ****************************************
// conversion timing
// ****************************************
`define UVRB_CONV_NS 282000
`define UVRB_CLK_NS 10

`endif

// [hdl/uvrb_id_converter.v]
// uvrb_id_converter.v: timed id resistor measurement sequencer.
// assumes start is a one-cycle pulse and code_in is settled by the end.
`timescale 1ns/1ps

module uvrb_id_converter #(
    parameter CYCLES = 28200
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire start,
    input wire [2:0] code_in,
    // results
    output reg busy,
    output reg finish,
    output reg [2:0] code
);

    // ****************************************
    // cycle counter
    // ****************************************
    reg [31:0] cnt_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 32'h0;
            busy <= 1'b0;
            finish <= 1'b0;
            code <= 3'h0;
        end else begin
            finish <= 1'b0;
            if (busy) begin
                if (cnt_reg == 32'h0) begin
                    busy <= 1'b0;
                    finish <= 1'b1;
                    code <= code_in;
                end else begin
                    cnt_reg <= cnt_reg - 32'h1;
                end
            end else if (start) begin
                busy <= 1'b1;
                cnt_reg <= CYCLES - 1;
            end
        end
    end

endmodule // uvrb_id_converter

// [hdl/uvrb_vendor_regs.v]
// uvrb_vendor_regs.v: vendor register bank of a ulpi transceiver.
// assumes the ulpi command decoder hands over single-cycle read and write
// strobes with address and data on the ulpi clock.
`timescale 1ns/1ps
`include "uvrb_map.vh"

module uvrb_vendor_regs #(
    parameter CONV_CYCLES = (`UVRB_CONV_NS + `UVRB_CLK_NS - 1) / `UVRB_CLK_NS
) (
    // clock and reset
    input wire SYS_CLK,
    input wire RSTN,
    // register access from the ulpi command decoder
    input wire REG_WR,
    input wire REG_RD,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    output reg REG_HIT,
    // carkit side
    input wire CARKIT_IRQ_ENABLE,
    input wire CARKIT_STATUS_RD,
    input wire CARKIT_LATCH_RD,
    output reg [7:0] CARKIT_STATUS,
    output reg ID_CONVERSION_LATCH,
    // mode inputs from the ulpi core (asynchronous to us)
    input wire UART_MODE,
    input wire AUDIO_MODE,
    input wire SERIAL_TRANSMIT_ENABLE,
    input wire [2:0] ID_MEASURE,
    // analog controls
    output reg [1:0] HS_TX_AMPLITUDE_BOOST,
    output reg HEADSET_AUDIO_ENABLE,
    output reg DATA_LINE_SWAP,
    output reg CHARGER_PULLUP_PLUS,
    output reg CHARGER_PULLUP_MINUS,
    output reg [1:0] REGULATED_SUPPLY_LEVEL,
    output reg ID_CONVERTER_ON,
    output reg ALT_INT
);

    // ****************************************
    // helpers
    // ****************************************
    // access kinds of an aliased register
    localparam [1:0] KIND_WRITE = 2'h0;
    localparam [1:0] KIND_SET = 2'h1;
    localparam [1:0] KIND_CLEAR = 2'h2;

    function [7:0] alias_update;
        input [7:0] cur;
        input [7:0] wdat;
        input [1:0] kind;
        begin
            case (kind)
                KIND_WRITE: alias_update = wdat;
                KIND_SET: alias_update = cur | wdat;
                KIND_CLEAR: alias_update = cur & ~wdat;
                default: alias_update = cur;
            endcase
        end
    endfunction

    // which alias of a register an address names; anything past the
    // set address inside the register's range is the clear alias
    function [1:0] alias_kind;
        input [5:0] addr;
        input [5:0] write_addr;
        input [5:0] set_addr;
        begin
            if (addr == write_addr) begin
                alias_kind = KIND_WRITE;
            end else if (addr == set_addr) begin
                alias_kind = KIND_SET;
            end else begin
                alias_kind = KIND_CLEAR;
            end
        end
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    // the id code is a slow static level; it is only captured once a full
    // conversion has elapsed, long after all three bits have settled
    reg uart_s1_reg, uart_s2_reg;
    reg audio_s1_reg, audio_s2_reg;
    reg txd_s1_reg, txd_s2_reg;
    reg [2:0] id_s1_reg, id_s2_reg;

    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            uart_s1_reg <= 1'b0;
            uart_s2_reg <= 1'b0;
            audio_s1_reg <= 1'b0;
            audio_s2_reg <= 1'b0;
            txd_s1_reg <= 1'b0;
            txd_s2_reg <= 1'b0;
            id_s1_reg <= 3'h0;
            id_s2_reg <= 3'h0;
        end else begin
            uart_s1_reg <= UART_MODE;
            uart_s2_reg <= uart_s1_reg;
            audio_s1_reg <= AUDIO_MODE;
            audio_s2_reg <= audio_s1_reg;
            txd_s1_reg <= SERIAL_TRANSMIT_ENABLE;
            txd_s2_reg <= txd_s1_reg;
            id_s1_reg <= ID_MEASURE;
            id_s2_reg <= id_s1_reg;
        end
    end

    wire uart_mode = uart_s2_reg;
    wire audio_mode = audio_s2_reg;
    wire txd_en = txd_s2_reg;

    // ****************************************
    // address decode
    // ****************************************
    wire in_window = (REG_ADDR >= `UVRB_WIN_LO) &&
        (REG_ADDR <= `UVRB_WIN_HI);
    wire wr_boost = REG_WR && REG_ADDR == `UVRB_A_BOOST;
    wire wr_hset = REG_WR && REG_ADDR == `UVRB_A_HSET;
    wire idc_hit = REG_ADDR >= `UVRB_A_IDC && REG_ADDR <= `UVRB_A_IDC_CLR;
    wire pwr_hit = REG_ADDR >= `UVRB_A_PWR && REG_ADDR <= `UVRB_A_PWR_CLR;
    wire wr_idc = REG_WR && idc_hit;
    wire wr_pwr = REG_WR && pwr_hit;
    // unmapped in-window addresses still hit but read as zero
    wire [1:0] idc_kind =
        alias_kind(REG_ADDR, `UVRB_A_IDC, `UVRB_A_IDC_SET);
    wire [1:0] pwr_kind =
        alias_kind(REG_ADDR, `UVRB_A_PWR, `UVRB_A_PWR_SET);
    wire rd_idc = REG_RD && in_window && idc_hit;

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] boost_reg, boost_next;
    reg [7:0] hset_reg, hset_next;
    reg [7:0] idc_reg, idc_next;
    reg [7:0] pwr_reg, pwr_next;
    reg done_reg, done_next;
    reg latch_reg, latch_next;
    reg [7:0] upd;
    reg launch;

    wire conv_busy;
    wire conv_finish;
    wire [2:0] conv_code;

    uvrb_id_converter #(
        .CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .start(launch),
        .code_in(id_s2_reg),
        .busy(conv_busy),
        .finish(conv_finish),
        .code(conv_code)
    );

    wire irq_en = idc_reg[`UVRB_IDC_IRQEN] | CARKIT_IRQ_ENABLE;

    always @* begin
        boost_next = boost_reg;
        hset_next = hset_reg;
        idc_next = idc_reg;
        pwr_next = pwr_reg;
        done_next = done_reg;
        latch_next = latch_reg;
        upd = 8'h00;
        launch = 1'b0;
        if (wr_boost) begin
            boost_next = REG_WDATA & `UVRB_BOOST_MASK;
        end
        if (wr_hset) begin
            hset_next = REG_WDATA & `UVRB_HSET_MASK;
        end
        if (wr_idc) begin
            // only start, reserved bit 5 and enable are writable
            upd = alias_update(idc_reg, REG_WDATA, idc_kind);
            idc_next = (idc_reg & ~`UVRB_IDC_WMASK) |
                (upd & `UVRB_IDC_WMASK);
            // only a written one on a plain or set access starts a run; a
            // clear access or a start bit still high from the run that is
            // ending must not restart the converter
            launch = REG_WDATA[`UVRB_IDC_START] &&
                idc_kind != KIND_CLEAR && !conv_busy;
        end
        if (wr_pwr) begin
            upd = alias_update(pwr_reg, REG_WDATA, pwr_kind);
            pwr_next = upd & `UVRB_PWR_WMASK;
        end
        // vendor read clears done; carkit status read does not
        if (rd_idc) begin
            done_next = 1'b0;
        end
        if (conv_finish) begin
            // finish beats a read in the same cycle
            // a start taken in this very cycle keeps its bit high
            idc_next[`UVRB_IDC_START] = launch;
            idc_next[2:0] = conv_code;
            done_next = 1'b1;
        end
        if (CARKIT_LATCH_RD) begin
            latch_next = 1'b0;
        end
        // only a 0 to 1 step of done latches, and it beats a clearing read
        if (conv_finish && irq_en && !done_reg) begin
            latch_next = 1'b1;
        end
    end

    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            boost_reg <= `UVRB_BOOST_RST;
            hset_reg <= `UVRB_HSET_RST;
            idc_reg <= `UVRB_IDC_RST;
            pwr_reg <= `UVRB_PWR_RST;
            done_reg <= 1'b0;
            latch_reg <= 1'b0;
        end else begin
            boost_reg <= boost_next;
            hset_reg <= hset_next;
            idc_reg <= idc_next;
            pwr_reg <= pwr_next;
            done_reg <= done_next;
            latch_reg <= latch_next;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        if (REG_ADDR == `UVRB_A_BOOST) begin
            rd_mux = boost_reg;
        end else if (REG_ADDR == `UVRB_A_HSET) begin
            rd_mux = hset_reg;
        end else if (idc_hit) begin
            rd_mux = idc_reg & ~(8'h01 << `UVRB_IDC_DONE);
            rd_mux[`UVRB_IDC_DONE] = done_reg;
        end else if (pwr_hit) begin
            rd_mux = pwr_reg;
        end
    end

    // ****************************************
    // control output next values
    // ****************************************
    // every control leaves through a flop, so the analog side never sees
    // a glitch from the decode or the mode synchronisers
    reg headset_next;
    reg pullup_plus_next;
    reg pullup_minus_next;
    reg [1:0] level_next;

    always @* begin
        headset_next = hset_reg[3:0] == `UVRB_HSET_KEY;
        // serial mode needs both pull-ups whatever the bits hold
        pullup_plus_next = pwr_reg[`UVRB_PWR_PUP] | uart_mode;
        pullup_minus_next = pwr_reg[`UVRB_PWR_PUM] | uart_mode;
        // audio outranks the serial level, which waits for transmit enable
        level_next = pwr_reg[`UVRB_PWR_USBLVL_LSB +: 2];
        if (audio_mode) begin
            level_next = `UVRB_LVL_3V3;
        end else if (uart_mode && txd_en) begin
            level_next = pwr_reg[`UVRB_PWR_ULVL_LSB +: 2];
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 8'h00;
            REG_HIT <= 1'b0;
            CARKIT_STATUS <= 8'h00;
            ID_CONVERSION_LATCH <= 1'b0;
            HS_TX_AMPLITUDE_BOOST <= 2'h0;
            HEADSET_AUDIO_ENABLE <= 1'b0;
            DATA_LINE_SWAP <= 1'b0;
            CHARGER_PULLUP_PLUS <= 1'b0;
            CHARGER_PULLUP_MINUS <= 1'b0;
            REGULATED_SUPPLY_LEVEL <= `UVRB_LVL_3V3;
            ID_CONVERTER_ON <= 1'b0;
            ALT_INT <= 1'b0;
        end else begin
            if (REG_RD) begin
                REG_RDATA <= in_window ? rd_mux : 8'h00;
            end
            REG_HIT <= (REG_RD || REG_WR) && in_window;
            // code and done mirrored for the carkit status register
            CARKIT_STATUS <= {1'b0, done_reg, idc_reg[2:0], 3'h0};
            ID_CONVERSION_LATCH <= latch_reg;
            HS_TX_AMPLITUDE_BOOST <= boost_reg[`UVRB_BOOST_LSB +: 2];
            HEADSET_AUDIO_ENABLE <= headset_next;
            // speaker routing lives elsewhere, so swap only moves dp/dm
            DATA_LINE_SWAP <= pwr_reg[`UVRB_PWR_SWAP];
            CHARGER_PULLUP_PLUS <= pullup_plus_next;
            CHARGER_PULLUP_MINUS <= pullup_minus_next;
            REGULATED_SUPPLY_LEVEL <= level_next;
            ID_CONVERTER_ON <= conv_busy;
            // level while done stands and enabled; rxcmd logic samples it
            ALT_INT <= irq_en & done_reg;
        end
    end

    // carkit status reads leave done alone by design; the port stays so
    // the carkit decoder need not treat that register specially
    wire unused_status_rd = CARKIT_STATUS_RD;

endmodule // uvrb_vendor_regs

// [verif/uvrb_vendor_regs_chk.sv]
// uvrb_vendor_regs_chk.sv: port assertions for the vendor register bank.
// assumes one clock and CONV_CYCLES matching the bound instance.
`timescale 1ns/1ps
module uvrb_vendor_regs_chk #(
    parameter CONV_CYCLES = 20
) (
    // clock and reset
    input wire SYS_CLK,
    input wire RSTN,
    // register access
    input wire REG_WR,
    input wire REG_RD,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    input wire REG_HIT,
    // modes and controls
    input wire UART_MODE,
    input wire AUDIO_MODE,
    input wire [1:0] HS_TX_AMPLITUDE_BOOST,
    input wire HEADSET_AUDIO_ENABLE,
    input wire DATA_LINE_SWAP,
    input wire CHARGER_PULLUP_PLUS,
    input wire CHARGER_PULLUP_MINUS,
    input wire [1:0] REGULATED_SUPPLY_LEVEL,
    input wire ID_CONVERTER_ON,
    input wire [7:0] CARKIT_STATUS,
    input wire ALT_INT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // ****
    // busy length counter
    // ****
    reg [15:0] busy_cnt_reg;
    always @(posedge SYS_CLK or negedge RSTN)
        if (!RSTN)
            busy_cnt_reg <= 16'h0000;
        else
            busy_cnt_reg <= ID_CONVERTER_ON ?
                busy_cnt_reg + 16'h0001 : 16'h0000;
    hit_window_a: assert property (1'b1 |=> REG_HIT ==
        $past((REG_WR || REG_RD) && REG_ADDR[5:4] == 2'h3))
        else $error("window hit flag wrong");
    boost_write_a: assert property (REG_WR && REG_ADDR == 6'h31 |->
        ##2 HS_TX_AMPLITUDE_BOOST == $past(REG_WDATA[6:5], 2))
        else $error("boost output wrong");
    key_match_a: assert property (REG_WR && REG_ADDR == 6'h33 |->
        ##2 HEADSET_AUDIO_ENABLE == ($past(REG_WDATA[3:0], 2) == 4'hA))
        else $error("headset key decode wrong");
    rsvd_zero_a: assert property (REG_RD && REG_ADDR == 6'h31 |=>
        REG_RDATA[4:0] == 5'h00 && !REG_RDATA[7])
        else $error("reserved boost bits not zero");
    swap_write_a: assert property (REG_WR && REG_ADDR == 6'h39 |->
        ##2 DATA_LINE_SWAP == $past(REG_WDATA[1], 2))
        else $error("swap output wrong");
    uart_pullup_a: assert property (UART_MODE [*4] |->
        CHARGER_PULLUP_PLUS && CHARGER_PULLUP_MINUS)
        else $error("pull-ups not forced in serial mode");
    audio_level_a: assert property (AUDIO_MODE [*4] |->
        REGULATED_SUPPLY_LEVEL == 2'h0)
        else $error("audio mode level not 3.3V");
    conv_len_a: assert property ($fell(ID_CONVERTER_ON) |->
        busy_cnt_reg >= CONV_CYCLES - 3 && busy_cnt_reg <= CONV_CYCLES + 1)
        else $error("conversion length wrong");
    alt_cause_a: assert property (ALT_INT |->
        CARKIT_STATUS[6] || $past(CARKIT_STATUS[6]))
        else $error("alt int without done");
endmodule // uvrb_vendor_regs_chk
bind uvrb_vendor_regs uvrb_vendor_regs_chk #(.CONV_CYCLES(CONV_CYCLES))
    u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_HIT(REG_HIT), .UART_MODE(UART_MODE), .AUDIO_MODE(AUDIO_MODE),
    .HS_TX_AMPLITUDE_BOOST(HS_TX_AMPLITUDE_BOOST), .HEADSET_AUDIO_ENABLE(HEADSET_AUDIO_ENABLE),
    .DATA_LINE_SWAP(DATA_LINE_SWAP), .CHARGER_PULLUP_PLUS(CHARGER_PULLUP_PLUS),
    .CHARGER_PULLUP_MINUS(CHARGER_PULLUP_MINUS),
    .REGULATED_SUPPLY_LEVEL(REGULATED_SUPPLY_LEVEL),
    .ID_CONVERTER_ON(ID_CONVERTER_ON), .CARKIT_STATUS(CARKIT_STATUS),
    .ALT_INT(ALT_INT));

// [verif/uvrb_link_model.sv]
// uvrb_link_model.sv: link side issuing immediate register accesses.
// assumes the bank samples strobes on the rising clock edge.
`timescale 1ns/1ps
module uvrb_link_model (
    // clock
    input wire clk,
    // register access
    output reg wr,
    output reg rd,
    output reg [5:0] addr,
    output reg [7:0] wdata,
    input wire [7:0] rdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
    end
    // released lines show inverted values so stale data cannot pass
    task wr_reg(input [5:0] a, input [7:0] d);
        begin
            @(negedge clk);
            addr = a;
            wdata = (a == 6'h36 || a == 6'h37) ? d & 8'hDF : d;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
            addr = ~a;
            wdata = ~wdata;
        end
    endtask
    task rd_reg(input [5:0] a, output [7:0] d);
        begin
            @(negedge clk);
            addr = a;
            rd = 1'b1;
            @(negedge clk);
            rd = 1'b0;
            addr = ~a;
            d = rdata;
        end
    endtask
endmodule // uvrb_link_model

// [verif/testbench.sv]
// testbench.sv: directed scenarios for the vendor register bank.
// assumes the link model drives register strobes on falling edges.
`timescale 1ns/1ps
module testbench;
    localparam CONV = 20;
    reg SYS_CLK, RSTN, CARKIT_IRQ_ENABLE, CARKIT_STATUS_RD, CARKIT_LATCH_RD;
    reg UART_MODE, AUDIO_MODE, SERIAL_TRANSMIT_ENABLE;
    reg [2:0] ID_MEASURE;
    wire REG_WR, REG_RD, REG_HIT, ID_CONVERSION_LATCH, HEADSET_AUDIO_ENABLE;
    wire DATA_LINE_SWAP, CHARGER_PULLUP_PLUS, CHARGER_PULLUP_MINUS;
    wire ID_CONVERTER_ON, ALT_INT;
    wire [5:0] REG_ADDR;
    wire [7:0] REG_WDATA, REG_RDATA, CARKIT_STATUS;
    wire [1:0] HS_TX_AMPLITUDE_BOOST, REGULATED_SUPPLY_LEVEL;
    integer err_total, comparisons, i, n;
    reg [7:0] rv;
    uvrb_vendor_regs #(.CONV_CYCLES(CONV)) u_uvrb_vendor_regs (
        .SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_HIT(REG_HIT), .CARKIT_IRQ_ENABLE(CARKIT_IRQ_ENABLE),
        .CARKIT_STATUS_RD(CARKIT_STATUS_RD), .CARKIT_LATCH_RD(CARKIT_LATCH_RD),
        .CARKIT_STATUS(CARKIT_STATUS), .ID_CONVERSION_LATCH(ID_CONVERSION_LATCH),
        .UART_MODE(UART_MODE), .AUDIO_MODE(AUDIO_MODE),
        .SERIAL_TRANSMIT_ENABLE(SERIAL_TRANSMIT_ENABLE), .ID_MEASURE(ID_MEASURE),
        .HS_TX_AMPLITUDE_BOOST(HS_TX_AMPLITUDE_BOOST), .HEADSET_AUDIO_ENABLE(HEADSET_AUDIO_ENABLE),
        .DATA_LINE_SWAP(DATA_LINE_SWAP), .CHARGER_PULLUP_PLUS(CHARGER_PULLUP_PLUS),
        .CHARGER_PULLUP_MINUS(CHARGER_PULLUP_MINUS),
        .REGULATED_SUPPLY_LEVEL(REGULATED_SUPPLY_LEVEL),
        .ID_CONVERTER_ON(ID_CONVERTER_ON), .ALT_INT(ALT_INT));
    uvrb_link_model u_uvrb_link_model (.clk(SYS_CLK), .wr(REG_WR),
        .rd(REG_RD), .addr(REG_ADDR), .wdata(REG_WDATA), .rdata(REG_RDATA));
    // ****
    // helpers
    // ****
    task chk(input string what, input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task rdchk(input [5:0] a, input [7:0] e);
        begin
            u_uvrb_link_model.rd_reg(a, rv);
            chk("read", rv, e);
        end
    endtask
    // sel 0 pulses the status read, anything else the latch read
    task pulse(input integer sel);
        begin
            @(negedge SYS_CLK);
            if (sel == 0) begin
                CARKIT_STATUS_RD = 1'b1;
            end else begin
                CARKIT_LATCH_RD = 1'b1;
            end
            @(negedge SYS_CLK);
            CARKIT_STATUS_RD = 1'b0;
            CARKIT_LATCH_RD = 1'b0;
            repeat (2) @(negedge SYS_CLK);
        end
    endtask
    // busy must run at least CONV-3 cycles, then fall within 200
    task wait_conv;
        begin
            n = 0;
            repeat (2) @(negedge SYS_CLK);
            while (ID_CONVERTER_ON === 1'b1 && n < 200) begin
                @(negedge SYS_CLK);
                n = n + 1;
            end
            repeat (2) @(negedge SYS_CLK);
            chk("conv len", n >= CONV - 3 && n < 200, 8'h01);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        begin
            rdchk(6'h31, 8'h00);
            rdchk(6'h33, 8'h00);
            rdchk(6'h36, 8'h00);
            rdchk(6'h39, 8'h04);
            chk("level", REGULATED_SUPPLY_LEVEL, 8'h00);
            $display("test reset done");
        end
    endtask
    task t_boost_key;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                u_uvrb_link_model.wr_reg(6'h31, {1'b1, i[1:0], 5'h1F});
                rdchk(6'h31, {1'b0, i[1:0], 5'h00});
                chk("boost", HS_TX_AMPLITUDE_BOOST, i[1:0]);
            end
            u_uvrb_link_model.wr_reg(6'h33, 8'hFA);
            rdchk(6'h33, 8'h0A);
            chk("audio key", HEADSET_AUDIO_ENABLE, 8'h01);
            u_uvrb_link_model.wr_reg(6'h33, 8'h0B);
            chk("audio key", HEADSET_AUDIO_ENABLE, 8'h01);
            rdchk(6'h33, 8'h0B);
            chk("audio key", HEADSET_AUDIO_ENABLE, 8'h00);
            $display("test boost and key done");
        end
    endtask
    task t_window;
        begin
            u_uvrb_link_model.wr_reg(6'h11, 8'hFF);
            rdchk(6'h31, 8'h60);
            rdchk(6'h10, 8'h00);
            chk("hit", REG_HIT, 8'h00);
            rdchk(6'h3F, 8'h00);
            chk("hit", REG_HIT, 8'h01);
            $display("test window done");
        end
    endtask
    task t_power;
        begin
            u_uvrb_link_model.wr_reg(6'h39, 8'hFF);
            rdchk(6'h3B, 8'hFE);
            chk("swap", DATA_LINE_SWAP, 8'h01);
            chk("pullups", {CHARGER_PULLUP_MINUS, CHARGER_PULLUP_PLUS}, 8'h03);
            chk("level", REGULATED_SUPPLY_LEVEL, 8'h03);
            u_uvrb_link_model.wr_reg(6'h3B, 8'h82);
            rdchk(6'h3A, 8'h7C);
            chk("swap", DATA_LINE_SWAP, 8'h00);
            u_uvrb_link_model.wr_reg(6'h3A, 8'h02);
            rdchk(6'h39, 8'h7E);
            u_uvrb_link_model.wr_reg(6'h39, 8'hC8);
            rdchk(6'h39, 8'hC8);
            UART_MODE = 1'b1;
            repeat (4) @(negedge SYS_CLK);
            chk("level", REGULATED_SUPPLY_LEVEL, 8'h03);
            SERIAL_TRANSMIT_ENABLE = 1'b1;
            repeat (4) @(negedge SYS_CLK);
            chk("level", REGULATED_SUPPLY_LEVEL, 8'h02);
            chk("pullups", {CHARGER_PULLUP_MINUS, CHARGER_PULLUP_PLUS}, 8'h03);
            AUDIO_MODE = 1'b1;
            repeat (4) @(negedge SYS_CLK);
            chk("level", REGULATED_SUPPLY_LEVEL, 8'h00);
            UART_MODE = 1'b0;
            AUDIO_MODE = 1'b0;
            SERIAL_TRANSMIT_ENABLE = 1'b0;
            RSTN = 1'b0;
            @(negedge SYS_CLK);
            RSTN = 1'b1;
            rdchk(6'h39, 8'h04);
            $display("test power done");
        end
    endtask
    task t_conv;
        begin
            ID_MEASURE = 3'h5;
            u_uvrb_link_model.wr_reg(6'h36, 8'h70);
            rdchk(6'h37, 8'h50);
            wait_conv;
            chk("status", CARKIT_STATUS, 8'h68);
            chk("alt int", ALT_INT, 8'h01);
            chk("latch", ID_CONVERSION_LATCH, 8'h01);
            pulse(0);
            chk("status", CARKIT_STATUS, 8'h68);
            rdchk(6'h36, 8'h4D);
            rdchk(6'h38, 8'h45);
            chk("alt int", ALT_INT, 8'h00);
            chk("latch", ID_CONVERSION_LATCH, 8'h01);
            pulse(1);
            chk("latch", ID_CONVERSION_LATCH, 8'h00);
            u_uvrb_link_model.wr_reg(6'h38, 8'h40);
            rdchk(6'h36, 8'h05);
            CARKIT_IRQ_ENABLE = 1'b1;
            ID_MEASURE = 3'h7;
            u_uvrb_link_model.wr_reg(6'h37, 8'h10);
            wait_conv;
            chk("alt int", ALT_INT, 8'h01);
            rdchk(6'h36, 8'h0F);
            $display("test conversion done");
        end
    endtask
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        tally_and_finish;
    end
    initial begin
        {RSTN, CARKIT_IRQ_ENABLE, CARKIT_STATUS_RD, CARKIT_LATCH_RD} = 4'h0;
        {UART_MODE, AUDIO_MODE, SERIAL_TRANSMIT_ENABLE, ID_MEASURE} = 6'h00;
        err_total = 0;
        comparisons = 0;
        repeat (8) @(negedge SYS_CLK);
        RSTN = 1'b1;
        t_reset;
        t_boost_key;
        t_window;
        t_power;
        t_conv;
        tally_and_finish;
    end
endmodule // testbench
